// file: hw/aux_adc_consts.svh
`ifndef AUX_ADC_CONSTS_SVH
`define AUX_ADC_CONSTS_SVH

// Register indices; byte address is four times the index
`define RESULT_IDX 16'h402D
`define CONTROL_IDX 16'h402E
`define SELECT_IDX 16'h402F
`define RESULT_ADDR ({`RESULT_IDX, 2'b00})
`define CONTROL_ADDR ({`CONTROL_IDX, 2'b00})
`define SELECT_ADDR ({`SELECT_IDX, 2'b00})

// Control fields
`define CTL_POWER_BIT 15
`define CTL_GO_BIT 14
`define CTL_SLEEP_BIT 12
`define CTL_RATE_MSB 5
`define CTL_RATE_LSB 0

// Select fields
`define SEL_SUPPLY_BIT 6
`define SEL_TEMP_BIT 4
`define SEL_PIN_C_BIT 2
`define SEL_PIN_B_BIT 1
`define SEL_PIN_A_BIT 0

// Result fields
`define TAG_MSB 15
`define TAG_LSB 12
`define DATA_MSB 11
`define DATA_LSB 0

// Source tag codes
`define TAG_PIN_A 4'h1
`define TAG_PIN_B 4'h2
`define TAG_PIN_C 4'h3
`define TAG_TEMP 4'h5
`define TAG_SUPPLY 4'h7

// Rate decode
`define RATE_MANUAL 6'h00
`define RATE_RESERVED 6'h20
`define RATE_LOW_MAX 6'h1F
`define RATE_LOW_MUL 2
`define RATE_HIGH_MUL 16

// Reset values
`define CONTROL_RESET 16'h0000
`define SELECT_RESET 16'h0000
`define RESULT_RESET 16'h0000

// Timing
`define CLK_PERIOD_NS 4
`define CLK_HZ_DEFAULT (1000000000 / `CLK_PERIOD_NS)

`endif

// file: hw/aux_adc_control.sv
// Functional notes
// - The upper nibble of the result names the source: 1, 2, 3 the pins, 5 die temperature, 7 the supply.
// - The low twelve bits of the result hold the unsigned code; millivolts are code times 1.465.
// - The converter is powered only while control bit 15 is one, and that bit clears in the OFF state.
// - With a nonzero rate other than 32, conversions repeat at that rate while bit 14 is one, which then stays set.
// - With rate zero, writing one to bit 14 starts one conversion and the bit clears when it ends.
// - Rate 0 is manual, 1 to 31 give twice the code per second, 32 is reserved, 33 to 63 give 16 times code less 32.
// - In SLEEP the converter follows bit 15 only when bit 12 is one, otherwise it is off.
// - The supply is measured only while select bit 6 is one.
// - Die temperature is measured only while select bit 4 is one.
// - Pins c, b and a are measured only while select bits 2, 1 and 0 are one.
`timescale 1ns/10ps
`include "aux_adc_consts.svh"
module aux_adc_control #(
    parameter int unsigned CLK_HZ = `CLK_HZ_DEFAULT
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device power state
    input wire logic pwr_off,
    input wire logic pwr_sleep,
    // Analogue converter
    output logic adc_power,
    output logic adc_start,
    output logic [3:0] adc_channel,
    input wire logic adc_done,
    input wire logic [11:0] adc_data
);
    aux_adc_pkg::ctl_reg_t s_q, s_d;
    aux_adc_if ifc ();

    logic setup;
    logic wr_en;
    logic hit_result;
    logic hit_control;
    logic hit_select;
    logic [15:0] control_view;
    logic [15:0] select_view;
    logic manual;
    logic powered;
    logic done_edge;
    logic go_write;

    sample_rate_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ifc(ifc.timer)
    );

    input_picker u_picker (
        .pclk(pclk),
        .presetn(presetn),
        .ifc(ifc.picker)
    );

    // Register views, reserved bits read as zero
    always_comb begin
        control_view = 16'h0000;
        control_view[`CTL_POWER_BIT] = s_q.pwr_en;
        control_view[`CTL_GO_BIT] = s_q.go;
        control_view[`CTL_SLEEP_BIT] = s_q.slp_hold;
        control_view[`CTL_RATE_MSB:`CTL_RATE_LSB] = s_q.rate;
        select_view = 16'h0000;
        select_view[`SEL_PIN_A_BIT] = s_q.sel[0];
        select_view[`SEL_PIN_B_BIT] = s_q.sel[1];
        select_view[`SEL_PIN_C_BIT] = s_q.sel[2];
        select_view[`SEL_TEMP_BIT] = s_q.sel[3];
        select_view[`SEL_SUPPLY_BIT] = s_q.sel[4];
    end

    assign setup = psel && !penable;
    assign hit_result = (paddr == `RESULT_ADDR);
    assign hit_control = (paddr == `CONTROL_ADDR);
    assign hit_select = (paddr == `SELECT_ADDR);
    // Writes commit in the access cycle, where pready is high
    assign wr_en = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
    assign go_write = wr_en && hit_control && pwdata[`CTL_GO_BIT];
    assign manual = (s_q.rate == `RATE_MANUAL);
    assign done_edge = s_q.done_sync[1] && !s_q.done_sync[2];

    // Sleep drops the converter unless the hold bit keeps it under the enable
    assign powered = s_q.pwr_en && !pwr_off && (!pwr_sleep || s_q.slp_hold);

    always_comb begin
        s_d = s_q;
        s_d.adc_start = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;

        // Converter done arrives from the analogue side: synchronise first
        s_d.done_sync = {s_q.done_sync[1:0], adc_done};

        // APB: decode in setup, answer in the single access cycle
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !(hit_result || hit_control || hit_select);
            if (hit_result) begin
                s_d.prdata = {16'h0000, s_q.result};
            end else if (hit_control) begin
                s_d.prdata = {16'h0000, control_view};
            end else if (hit_select) begin
                s_d.prdata = {16'h0000, select_view};
            end else begin
                s_d.prdata = 32'h0000_0000;
            end
        end

        // Conversion sequence; a control write in flight defers the start so power and start agree
        case (s_q.state)
            aux_adc_pkg::ST_IDLE: begin
                if (powered && s_q.go && ifc.chan_ok && (manual || s_q.tick_pend) && !(wr_en && hit_control)) begin
                    s_d.state = aux_adc_pkg::ST_START;
                    s_d.adc_start = 1'b1;
                    s_d.tick_pend = 1'b0;
                end
            end
            aux_adc_pkg::ST_START: begin
                s_d.state = aux_adc_pkg::ST_WAIT;
            end
            aux_adc_pkg::ST_WAIT: begin
                if (!powered) begin
                    // Power loss abandons the conversion; no result is posted
                    s_d.state = aux_adc_pkg::ST_IDLE;
                end else if (done_edge) begin
                    s_d.state = aux_adc_pkg::ST_IDLE;
                    s_d.result = {adc_channel, adc_data};
                    if (manual) begin
                        s_d.go = 1'b0;
                    end
                end
            end
            default: begin
                s_d.state = aux_adc_pkg::ST_IDLE;
            end
        endcase

        // A tick in the cycle of a start still pends: set beats the start's clear
        if (ifc.tick) begin
            s_d.tick_pend = 1'b1;
        end

        // Software writes; a write of one to go beats the completion clear
        if (wr_en && hit_control) begin
            s_d.pwr_en = pwdata[`CTL_POWER_BIT];
            s_d.go = pwdata[`CTL_GO_BIT];
            s_d.slp_hold = pwdata[`CTL_SLEEP_BIT];
            s_d.rate = pwdata[`CTL_RATE_MSB:`CTL_RATE_LSB];
        end
        if (go_write) begin
            s_d.go = 1'b1;
        end
        if (wr_en && hit_select) begin
            s_d.sel[0] = pwdata[`SEL_PIN_A_BIT];
            s_d.sel[1] = pwdata[`SEL_PIN_B_BIT];
            s_d.sel[2] = pwdata[`SEL_PIN_C_BIT];
            s_d.sel[3] = pwdata[`SEL_TEMP_BIT];
            s_d.sel[4] = pwdata[`SEL_SUPPLY_BIT];
        end

        // OFF state forces the enable low over any write
        if (pwr_off) begin
            s_d.pwr_en = 1'b0;
        end

        // Stale ticks from a stopped rate must not fire later
        if (manual || !s_q.go || !powered) begin
            s_d.tick_pend = 1'b0;
        end

        s_d.adc_power = s_d.pwr_en && !pwr_off && (!pwr_sleep || s_d.slp_hold);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{
                state: aux_adc_pkg::ST_IDLE,
                pwr_en: 1'(`CONTROL_RESET >> `CTL_POWER_BIT),
                go: 1'b0,
                slp_hold: 1'b0,
                rate: 6'h00,
                sel: 5'h00,
                result: `RESULT_RESET,
                done_sync: 3'h0,
                tick_pend: 1'b0,
                prdata: 32'h0000_0000,
                pready: 1'b0,
                pslverr: 1'b0,
                adc_power: 1'b0,
                adc_start: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Timer runs only while auto conversions are armed and the converter is live
    assign ifc.rate = s_q.rate;
    assign ifc.run = s_q.go && powered && !manual;
    assign ifc.sel = s_q.sel;
    assign ifc.advance = (s_q.state == aux_adc_pkg::ST_WAIT) && powered && done_edge;

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign adc_power = s_q.adc_power;
    assign adc_start = s_q.adc_start;
    assign adc_channel = ifc.code;
endmodule // aux_adc_control

// file: hw/aux_adc_if.sv
`timescale 1ns/10ps
interface aux_adc_if;
    logic [5:0] rate;
    logic run;
    logic tick;
    logic [4:0] sel;
    logic advance;
    logic [3:0] code;
    logic chan_ok;

    modport ctrl (output rate, output run, input tick, output sel, output advance, input code, input chan_ok);
    modport timer (input rate, input run, output tick);
    modport picker (input sel, input advance, output code, output chan_ok);
endinterface

// file: hw/aux_adc_pkg.sv
package aux_adc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_WAIT = 3'b100
    } ctl_state_t;

    typedef struct packed {
        ctl_state_t state;
        logic pwr_en;
        logic go;
        logic slp_hold;
        logic [5:0] rate;
        logic [4:0] sel;
        logic [15:0] result;
        logic [2:0] done_sync;
        logic tick_pend;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic adc_power;
        logic adc_start;
    } ctl_reg_t;

    typedef struct packed {
        logic [31:0] acc;
        logic tick;
    } timer_reg_t;

    typedef struct packed {
        logic [2:0] slot;
        logic [3:0] code;
    } picker_reg_t;

endpackage

// file: hw/input_picker.sv
`timescale 1ns/10ps
`include "aux_adc_consts.svh"
module input_picker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control side
    aux_adc_if.picker ifc
);
    localparam int N = 5;
    localparam logic [3:0] TAGS [N] = '{`TAG_PIN_A, `TAG_PIN_B, `TAG_PIN_C, `TAG_TEMP, `TAG_SUPPLY};

    aux_adc_pkg::picker_reg_t s_q, s_d;
    logic [N-1:0] rot;

    // Mask rotated so that entry k is the input k+1 places after the current one
    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_rot
            assign rot[k] = ifc.sel[(32'(s_q.slot) + k + 1) % N];
        end
    endgenerate

    // Round robin over the selected inputs; a deselected slot is left at once
    always_comb begin
        logic found;
        found = 1'b0;
        s_d = s_q;
        if (ifc.advance || !ifc.sel[s_q.slot]) begin
            for (int i = 0; i < N; i++) begin
                if (rot[i] && !found) begin
                    found = 1'b1;
                    s_d.slot = 3'((32'(s_q.slot) + i + 1) % N);
                end
            end
        end
        s_d.code = TAGS[s_d.slot];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{slot: 3'h0, code: `TAG_PIN_A};
        end else begin
            s_q <= s_d;
        end
    end

    assign ifc.code = s_q.code;
    assign ifc.chan_ok = ifc.sel[s_q.slot];
endmodule // input_picker

// file: hw/sample_rate_timer.sv
`timescale 1ns/10ps
`include "aux_adc_consts.svh"
module sample_rate_timer #(
    parameter int unsigned CLK_HZ = `CLK_HZ_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control side
    aux_adc_if.timer ifc
);
    localparam logic [31:0] CLK_HZ_W = 32'(CLK_HZ);

    aux_adc_pkg::timer_reg_t s_q, s_d;
    logic [31:0] sps;
    logic [31:0] sum;

    // Phase accumulator keeps the average rate exact without a divider
    always_comb begin
        sps = 32'h0000_0000;
        if (ifc.rate != `RATE_RESERVED && ifc.rate != `RATE_MANUAL) begin
            if (ifc.rate <= `RATE_LOW_MAX) begin
                sps = 32'({26'h000_0000, ifc.rate} * `RATE_LOW_MUL);
            end else begin
                sps = 32'({26'h000_0000, ifc.rate - 6'h20} * `RATE_HIGH_MUL);
            end
        end
        sum = s_q.acc + sps;
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!ifc.run || sps == 32'h0000_0000) begin
            s_d.acc = 32'h0000_0000;
        end else if (sum >= CLK_HZ_W) begin
            s_d.acc = sum - CLK_HZ_W;
            s_d.tick = 1'b1;
        end else begin
            s_d.acc = sum;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ifc.tick = s_q.tick;
endmodule // sample_rate_timer

// file: tb/aux_adc_control_sva.sv
`timescale 1ns/10ps
`include "aux_adc_consts.svh"
module aux_adc_control_sva #(
    parameter int unsigned CLK_HZ = `CLK_HZ_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power state
    input wire logic pwr_off,
    input wire logic pwr_sleep,
    // Converter
    input wire logic adc_power,
    input wire logic adc_start,
    input wire logic [3:0] adc_channel,
    input wire logic adc_done,
    input wire logic [11:0] adc_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr == `RESULT_ADDR || paddr == `CONTROL_ADDR || paddr == `SELECT_ADDR;

    chk_ready_slot: assert property (psel && !penable |=> pready) else $error("no access cycle");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    chk_error_map: assert property (pready |-> pslverr == !mapped) else $error("bad error response");
    chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
    chk_off_unpowers: assert property (pwr_off |=> !adc_power) else $error("powered in off");
    chk_start_powered: assert property (adc_start |-> adc_power) else $error("start unpowered");
    chk_start_pulse: assert property (adc_start |=> !adc_start) else $error("start too long");
    chk_channel_code: assert property (
        adc_start |-> adc_channel inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h7}) else $error("bad channel code");
    chk_channel_hold: assert property (adc_start |=> $stable(adc_channel)[*4]) else $error("channel moved");

    cover property (adc_start);
    cover property (pready && pslverr);
    cover property (pwr_sleep && adc_power);
endmodule // aux_adc_control_sva

bind aux_adc_control aux_adc_control_sva #(.CLK_HZ(CLK_HZ)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwr_off(pwr_off), .pwr_sleep(pwr_sleep), .adc_power(adc_power), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data));

// file: tb/testbench.sv
`timescale 1ns/10ps
`include "aux_adc_consts.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pwr_off, pwr_sleep, adc_done;
    logic pready, pslverr, adc_power, adc_start, last_err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] adc_channel, last_ch;
    logic [11:0] adc_data, next_data;
    logic [3:0] chs [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
    int n_errors = 0;
    int total_checks = 0;
    int n_starts = 0;

    // Small clock rate keeps sample periods short
    aux_adc_control #(.CLK_HZ(1000)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_off(pwr_off), .pwr_sleep(pwr_sleep), .adc_power(adc_power), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Converter stand-in: answers every start, done held 3 clocks
    initial begin
        adc_done = 1'b0;
        adc_data = 12'h000;
        forever begin
            @(posedge pclk);
            if (adc_start === 1'b1) begin
                n_starts++;
                last_ch = adc_channel;
                repeat (2) @(posedge pclk);
                adc_data <= next_data;
                adc_done <= 1'b1;
                repeat (3) @(posedge pclk);
                adc_done <= 1'b0;
            end
        end
    end

    task manual(input logic [3:0] ch, input logic [11:0] d);
        int n;
        int s;
        s = n_starts;
        next_data = d;
        apb(1'b1, `CONTROL_ADDR, 32'h0000C000);
        n = 0;
        while (n_starts == s && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            n_errors++;
            print_verdict();
        end
        check(last_ch, ch);
        repeat (14) @(posedge pclk);
        apb(1'b0, `RESULT_ADDR, 32'h0);
        check(rd, {16'h0000, ch, d});
        apb(1'b0, `CONTROL_ADDR, 32'h0);
        check(rd, 32'h00008000);
    endtask

    task count_for(input int cycles, input int exp);
        int s;
        s = n_starts;
        repeat (cycles) @(posedge pclk);
        check(n_starts - s, exp);
    endtask

    task scen_regs;
        apb(1'b0, `RESULT_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `CONTROL_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `SELECT_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 18'h00000, 32'h0000FFFF);
        check(last_err, 1'b1);
        apb(1'b1, `RESULT_ADDR, 32'h0000FFFF);
        apb(1'b0, `RESULT_ADDR, 32'h0);
        check(last_err, 1'b0);
        check(rd, 32'h0);
    endtask

    task scen_rotate;
        apb(1'b1, `SELECT_ADDR, 32'h00000057);
        apb(1'b0, `SELECT_ADDR, 32'h0);
        check(rd, 32'h00000057);
        for (int i = 0; i < 6; i++)
            manual(chs[i % 5], (i == 3) ? 12'h1F2 : 12'hA50 + 12'(i));
    endtask

    task scen_rate;
        apb(1'b1, `CONTROL_ADDR, 32'h0000C001);
        count_for(1100, 2);
        apb(1'b0, `CONTROL_ADDR, 32'h0);
        check(rd, 32'h0000C001);
        apb(1'b1, `CONTROL_ADDR, 32'h00008001);
        count_for(600, 0);
        apb(1'b1, `CONTROL_ADDR, 32'h0000C021);
        count_for(1030, 16);
        apb(1'b1, `CONTROL_ADDR, 32'h00008000);
        repeat (20) @(posedge pclk);
        apb(1'b1, `CONTROL_ADDR, 32'h0000C020);
        count_for(1100, 0);
    endtask

    task scen_power;
        apb(1'b1, `CONTROL_ADDR, 32'h00008000);
        repeat (3) @(posedge pclk);
        check(adc_power, 1'b1);
        pwr_sleep <= 1'b1;
        repeat (3) @(posedge pclk);
        check(adc_power, 1'b0);
        apb(1'b1, `CONTROL_ADDR, 32'h00009000);
        repeat (3) @(posedge pclk);
        check(adc_power, 1'b1);
        pwr_sleep <= 1'b0;
        pwr_off <= 1'b1;
        repeat (3) @(posedge pclk);
        check(adc_power, 1'b0);
        pwr_off <= 1'b0;
        apb(1'b0, `CONTROL_ADDR, 32'h0);
        check(rd, 32'h00001000);
        check(adc_power, 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h0;
        pwr_off = 1'b0;
        pwr_sleep = 1'b0;
        next_data = 12'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        scen_regs();
        scen_rotate();
        scen_rate();
        scen_power();
        print_verdict();
    end
endmodule // testbench
